/* src/ccsu_pkg.sv */
// Package: encodings, field positions and reset values for the common command and status unit
// Functional notes
// RULE1 - Option query returns fixed keyword list, zeros absent
// RULE2 - Clear flag set: masks zero after power-up
// RULE3 - Clear flag off: masks restored from storage
// RULE4 - Recall restores whole state, slots 0..7
// RULE5 - Recall forces calibration off, trigger idle
// RULE6 - Reset loads factory default settings
// RULE7 - Reset or device-clear clears events, keeps enables
// RULE8 - Serial reset acts like parallel device-clear
// RULE9 - Save writes state into one of eight slots
// RULE10 - Bit 6 is OR of enabled byte bits
// RULE11 - Serial poll clears request bit, keeps summary
// RULE12 - Zero service mask never raises request
// RULE13 - Status byte fields at bits seven to three
// RULE14 - Status byte query clears nothing
// RULE15 - Poll reply shows request bit at 6
// RULE16 - Summary bit clears when feeding register read
// RULE17 - Trigger command pulses every bus-sourced subsystem
// RULE18 - Output, relay, trigger commands run overlapped
// RULE19 - Wait holds commands until overlapped work done
// RULE20 - Any further command cancels a pending wait; a further WAI instead keeps the hold while overlapped work is pending
// RULE21 - Event summary is OR of enabled events
// RULE22 - Reading standard event register clears it
package ccsu_pkg;
  // Command codes presented on the command port
  typedef enum logic [3:0] {
    CCSU_CMD_NONE, CCSU_CMD_OPT, CCSU_CMD_PSC, CCSU_CMD_RCL, CCSU_CMD_RST,
    CCSU_CMD_SAV, CCSU_CMD_SRE, CCSU_CMD_STB, CCSU_CMD_TRG, CCSU_CMD_WAI,
    CCSU_CMD_ESR, CCSU_CMD_ESE, CCSU_CMD_POLL, CCSU_CMD_OTHER
  } ccsu_cmd_t;
  // Status byte field positions
  localparam int CCSU_SB_OPERATION = 7;
  localparam int CCSU_SB_MASTER = 6;
  localparam int CCSU_SB_EVENT = 5;
  localparam int CCSU_SB_MSG_AVAIL = 4;
  localparam int CCSU_SB_QUESTIONABLE = 3;
  // Standard event bit raised at power-on
  localparam int CCSU_SE_POWER_ON = 7;
  localparam int CCSU_SLOTS = 8;
  localparam int CCSU_OPT_COUNT = 14;
  localparam logic [7:0] CCSU_MASK_RST = 8'h00;
  // Factory defaults loaded by reset
  localparam int CCSU_PROT_DELAY_MS = 100;
  localparam logic [15:0] CCSU_PROT_DELAY_RST = 16'(CCSU_PROT_DELAY_MS);
  localparam logic [15:0] CCSU_FREQ_RST = 16'h003c;
  localparam logic [15:0] CCSU_PHASE_RST = 16'h0000;
  localparam logic CCSU_SRC_IMM = 1'b0;
  localparam logic CCSU_SRC_BUS = 1'b1;
  // Saved state image
  typedef struct packed {
    logic cont_init;
    logic [15:0] prot_delay;
    logic [15:0] freq;
    logic [15:0] phase;
    logic trig_src;
    logic sync_src;
    logic [7:0] list_id;
  } ccsu_state_t;
  localparam ccsu_state_t CCSU_STATE_RST = '{1'b0, CCSU_PROT_DELAY_RST, CCSU_FREQ_RST,
    CCSU_PHASE_RST, CCSU_SRC_IMM, CCSU_SRC_IMM, 8'h00};
  localparam int CCSU_STATE_W = $bits(ccsu_state_t);
endpackage

/* src/ccsu_slot_if.sv */
// Interface: save and recall port of the state slot store
`timescale 1ns/10ps
interface ccsu_slot_if;
  import ccsu_pkg::*;
  logic wr;
  logic [2:0] idx;
  ccsu_state_t wdata;
  ccsu_state_t rdata;
  modport ctrl (output wr, output idx, output wdata, input rdata);
  modport store (input wr, input idx, input wdata, output rdata);
endinterface

/* src/ccsu_slot_store.sv */
// Eight-slot state store, contents kept across resets like nonvolatile memory
`timescale 1ns/10ps
module ccsu_slot_store
  import ccsu_pkg::*;
#(
  parameter int SLOTS = CCSU_SLOTS
) (
  // Clock
  input wire logic i_core_clk,
  // Slot port
  ccsu_slot_if.store slot
);
  ccsu_state_t mem_r [SLOTS];
  // No reset: the slots model storage that survives power cycles
  always_ff @(posedge i_core_clk) begin
    if (slot.wr) begin
      mem_r[slot.idx] <= slot.wdata; // [RULE9]
    end
  end
  assign slot.rdata = mem_r[slot.idx]; // [RULE4]
endmodule

/* src/ccsu_top.sv */
// Common command interpreter: status byte, service request, save, recall, reset, wait
`timescale 1ns/10ps
module ccsu_top
  import ccsu_pkg::*;
#(
  parameter logic [CCSU_OPT_COUNT-1:0] OPT_INSTALLED = 14'h0001
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  // Command port from the parser
  input wire logic i_cmd_valid,
  input wire ccsu_cmd_t i_cmd,
  input wire logic [7:0] i_cmd_arg,
  input wire logic i_cmd_serial,
  input wire logic i_dev_clear,
  input wire logic i_get,
  // Summary inputs from other status groups
  input wire logic i_operation_sum,
  input wire logic i_questionable_sum,
  input wire logic i_msg_avail,
  input wire logic [7:0] i_std_event_set,
  input wire logic i_operation_read,
  input wire logic i_questionable_read,
  // Overlapped command tracking
  input wire logic i_ovl_start,
  input wire logic i_ovl_done,
  // Power-on clear flag as held in storage
  input wire logic i_psc_nv,
  // Replies
  output logic o_resp_valid,
  output logic [7:0] o_resp_data,
  output logic [CCSU_OPT_COUNT-1:0] o_opt_list,
  output logic o_srq,
  output logic o_hold,
  output logic o_trig_bus,
  output logic o_abort,
  output logic o_clear_events,
  output logic o_cal_enable,
  // Active settings
  output ccsu_state_t o_state,
  output logic o_psc
);
  typedef struct packed {
    logic [7:0] sre;
    logic [7:0] ese;
    logic [7:0] esr;
    logic operation_sum;
    logic questionable_sum;
    logic svc_req;
    logic master_prev;
    logic psc;
    logic pwr_done;
    logic [7:0] ovl_cnt;
    logic wait_hold;
    logic cal;
    ccsu_state_t st;
    logic resp_valid;
    logic [7:0] resp_data;
    logic srq;
    logic trig_bus;
    logic abort;
    logic clr;
  } ccsu_regs_t;

  ccsu_regs_t q_r;
  ccsu_regs_t q_nxt;
  // Restore copy of the enable masks; unknown until first written by a PSC command, or by SRE/ESE with the clear flag off, like an unwritten slot
  logic [7:0] nv_sre_r;
  logic [7:0] nv_sre_nxt;
  logic [7:0] nv_ese_r;
  logic [7:0] nv_ese_nxt;
  ccsu_slot_if slot ();

  ccsu_slot_store #(.SLOTS(CCSU_SLOTS)) u_store (
    .i_core_clk(i_core_clk),
    .slot(slot)
  );

  function automatic logic [7:0] stb_value(input ccsu_regs_t r, input logic msg_avail);
    logic [7:0] b;
    logic event_sum;
    b = 8'h00;
    event_sum = |(r.esr & r.ese); // [RULE21]
    b[CCSU_SB_OPERATION] = r.operation_sum; // [RULE13]
    b[CCSU_SB_EVENT] = event_sum;
    b[CCSU_SB_MSG_AVAIL] = msg_avail;
    b[CCSU_SB_QUESTIONABLE] = r.questionable_sum;
    b[CCSU_SB_MASTER] = |(b & r.sre); // [RULE10]
    return b;
  endfunction

  logic go;
  logic [7:0] stb;
  logic clear_req;
  logic master_sum;

  // Commands run even under a wait hold: a new command is what cancels the hold
  assign go = i_cmd_valid;
  assign stb = stb_value(q_r, i_msg_avail);
  assign master_sum = stb[CCSU_SB_MASTER];
  assign clear_req = i_dev_clear || (i_cmd_valid && i_cmd == CCSU_CMD_RST); // [RULE7] [RULE8]
  assign slot.idx = i_cmd_arg[2:0];
  assign slot.wr = i_cmd_valid && i_cmd == CCSU_CMD_SAV && i_cmd_arg < 8'(CCSU_SLOTS);
  assign slot.wdata = q_r.st; // [RULE9]

  always_comb begin
    q_nxt = q_r;
    nv_sre_nxt = nv_sre_r;
    nv_ese_nxt = nv_ese_r;
    q_nxt.resp_valid = 1'b0;
    q_nxt.trig_bus = 1'b0;
    q_nxt.abort = 1'b0;
    q_nxt.clr = 1'b0;
    // Power-up: restore or clear masks once after reset release
    if (!q_r.pwr_done) begin
      q_nxt.pwr_done = 1'b1;
      q_nxt.psc = i_psc_nv;
      if (i_psc_nv) begin
        q_nxt.sre = CCSU_MASK_RST; // [RULE2]
        q_nxt.ese = CCSU_MASK_RST;
      end else begin
        q_nxt.sre = nv_sre_r; // [RULE3]
        q_nxt.ese = nv_ese_r;
      end
      q_nxt.esr[CCSU_SE_POWER_ON] = 1'b1;
    end
    // Summary sources: a read clears, a new set in the same cycle wins
    if (i_operation_read) q_nxt.operation_sum = 1'b0; // [RULE16]
    if (i_questionable_read) q_nxt.questionable_sum = 1'b0;
    if (i_operation_sum) q_nxt.operation_sum = 1'b1;
    if (i_questionable_sum) q_nxt.questionable_sum = 1'b1;
    // Overlapped command counter; wait hold releases when it drains
    if (i_ovl_start && !i_ovl_done) q_nxt.ovl_cnt = q_r.ovl_cnt + 8'h01; // [RULE18]
    else if (!i_ovl_start && i_ovl_done && q_r.ovl_cnt != 8'h00)
      q_nxt.ovl_cnt = q_r.ovl_cnt - 8'h01;
    if (q_r.wait_hold && q_nxt.ovl_cnt == 8'h00) q_nxt.wait_hold = 1'b0; // [RULE19]
    if (i_get) q_nxt.trig_bus = 1'b1;
    if (go) begin
      if (q_r.wait_hold && i_cmd != CCSU_CMD_WAI) q_nxt.wait_hold = 1'b0; // [RULE20]
      case (i_cmd)
        CCSU_CMD_OPT: begin
          q_nxt.resp_valid = 1'b1; // [RULE1]
          q_nxt.resp_data = 8'(CCSU_OPT_COUNT);
        end
        CCSU_CMD_PSC: begin
          q_nxt.psc = i_cmd_arg != 8'h00;
          nv_sre_nxt = q_r.sre;
          nv_ese_nxt = q_r.ese;
        end
        CCSU_CMD_RCL: begin
          if (i_cmd_arg < 8'(CCSU_SLOTS)) begin
            q_nxt.st = slot.rdata; // [RULE4]
            q_nxt.cal = 1'b0; // [RULE5]
            q_nxt.abort = 1'b1;
          end
        end
        CCSU_CMD_RST: begin
          q_nxt.st = CCSU_STATE_RST; // [RULE6]
          q_nxt.abort = 1'b1;
        end
        CCSU_CMD_SRE: begin
          q_nxt.sre = i_cmd_arg; // [RULE10]
          if (!q_r.psc) nv_sre_nxt = i_cmd_arg;
        end
        CCSU_CMD_ESE: begin
          q_nxt.ese = i_cmd_arg;
          if (!q_r.psc) nv_ese_nxt = i_cmd_arg;
        end
        CCSU_CMD_STB: begin
          q_nxt.resp_valid = 1'b1; // [RULE14]
          q_nxt.resp_data = stb;
        end
        CCSU_CMD_POLL: begin
          q_nxt.resp_valid = 1'b1;
          q_nxt.resp_data = {stb[7], q_r.svc_req, stb[5:0]}; // [RULE15]
          q_nxt.svc_req = 1'b0; // [RULE11]
        end
        CCSU_CMD_ESR: begin
          q_nxt.resp_valid = 1'b1;
          q_nxt.resp_data = q_r.esr;
          q_nxt.esr = 8'h00; // [RULE22]
        end
        CCSU_CMD_TRG: q_nxt.trig_bus = 1'b1; // [RULE17]
        CCSU_CMD_WAI: q_nxt.wait_hold = q_r.ovl_cnt != 8'h00 || i_ovl_start; // [RULE19]
        default: ;
      endcase
    end
    if (clear_req) begin
      q_nxt.esr = 8'h00; // [RULE7]
      q_nxt.operation_sum = 1'b0;
      q_nxt.questionable_sum = 1'b0;
      q_nxt.svc_req = 1'b0;
      q_nxt.clr = 1'b1;
      q_nxt.wait_hold = 1'b0;
    end
    // New events win over a clear in the same cycle
    q_nxt.esr = q_nxt.esr | i_std_event_set;
    // Request raised on rising summary; zero mask keeps it low
    if (master_sum && !q_r.master_prev && q_r.sre != 8'h00) q_nxt.svc_req = 1'b1; // [RULE12]
    q_nxt.master_prev = master_sum;
    q_nxt.srq = q_nxt.svc_req && q_r.sre != 8'h00; // [RULE12]
  end

  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      q_r <= '0;
      q_r.st <= CCSU_STATE_RST;
    end else begin
      q_r <= q_nxt;
    end
  end

  // No reset: this copy stands in for storage that survives power cycles
  always_ff @(posedge i_core_clk) begin
    if (!i_sys_rst) begin
      nv_sre_r <= nv_sre_nxt; // [RULE3]
      nv_ese_r <= nv_ese_nxt;
    end
  end

  // Option list is fixed by build; a zero bit marks an absent feature
  logic [CCSU_OPT_COUNT-1:0] opt_r;
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) opt_r <= '0;
    else opt_r <= OPT_INSTALLED; // [RULE1]
  end

  assign o_resp_valid = q_r.resp_valid;
  assign o_resp_data = q_r.resp_data;
  assign o_opt_list = opt_r;
  assign o_srq = q_r.srq;
  assign o_hold = q_r.wait_hold;
  assign o_trig_bus = q_r.trig_bus;
  assign o_abort = q_r.abort;
  assign o_clear_events = q_r.clr;
  assign o_cal_enable = q_r.cal;
  assign o_state = q_r.st;
  assign o_psc = q_r.psc;
endmodule

/* tb/ccsu_monitor.sv */
// Port checker for the common command and status unit
`timescale 1ns/10ps
module ccsu_monitor
  import ccsu_pkg::*;
#(
  parameter logic [CCSU_OPT_COUNT-1:0] OPT_INSTALLED = 14'h0001
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  // Commands
  input wire logic i_cmd_valid,
  input wire ccsu_cmd_t i_cmd,
  input wire logic [7:0] i_cmd_arg,
  input wire logic i_dev_clear,
  input wire logic i_get,
  // Replies
  input wire logic o_resp_valid,
  input wire logic [7:0] o_resp_data,
  input wire logic [CCSU_OPT_COUNT-1:0] o_opt_list,
  input wire logic o_srq,
  input wire logic o_hold,
  input wire logic o_trig_bus,
  input wire logic o_abort,
  input wire logic o_clear_events,
  input wire logic o_cal_enable,
  input wire ccsu_state_t o_state
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst);
  logic sre_zero_r;
  // Mask after power-up depends on the stored flag, so start unknown-safe at 0
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      sre_zero_r <= 1'b0;
    end else if (i_cmd_valid && i_cmd == CCSU_CMD_SRE) begin
      sre_zero_r <= (i_cmd_arg == 8'h00);
    end
  end
  property p_opt;
    i_cmd_valid && i_cmd == CCSU_CMD_OPT |=> o_resp_valid && o_opt_list == OPT_INSTALLED;
  endproperty
  a_opt: assert property (p_opt) else $error("option reply wrong");
  property p_stb;
    i_cmd_valid && i_cmd == CCSU_CMD_STB |=> o_resp_valid && o_resp_data[2:0] == 3'h0;
  endproperty
  a_stb: assert property (p_stb) else $error("status reply wrong");
  property p_poll;
    i_cmd_valid && i_cmd == CCSU_CMD_POLL |=> o_resp_valid ##1 !o_srq;
  endproperty
  a_poll: assert property (p_poll) else $error("poll kept request");
  property p_nosrq;
    sre_zero_r && $past(sre_zero_r) |-> !$rose(o_srq);
  endproperty
  a_nosrq: assert property (p_nosrq) else $error("request with zero mask");
  property p_trg;
    (i_cmd_valid && i_cmd == CCSU_CMD_TRG) || i_get |-> ##[1:2] o_trig_bus;
  endproperty
  a_trg: assert property (p_trg) else $error("no bus trigger");
  property p_clr;
    (i_cmd_valid && i_cmd == CCSU_CMD_RST) || i_dev_clear |-> ##[1:2] o_clear_events;
  endproperty
  a_clr: assert property (p_clr) else $error("events not cleared");
  property p_rst;
    i_cmd_valid && i_cmd == CCSU_CMD_RST |-> ##[1:2] o_state == CCSU_STATE_RST;
  endproperty
  a_rst: assert property (p_rst) else $error("defaults not loaded");
  property p_rcl;
    i_cmd_valid && i_cmd == CCSU_CMD_RCL && i_cmd_arg <= 8'h07
      |=> o_abort && !o_cal_enable;
  endproperty
  a_rcl: assert property (p_rcl) else $error("recall missed abort");
  property p_wai;
    o_hold && i_cmd_valid && i_cmd != CCSU_CMD_WAI |=> !o_hold;
  endproperty
  a_wai: assert property (p_wai) else $error("wait not cancelled");
  c_hold: cover property (o_hold);
  c_srq: cover property (o_srq);
  c_abort: cover property (o_abort);
endmodule
bind ccsu_top ccsu_monitor #(.OPT_INSTALLED(OPT_INSTALLED)) ccsu_monitor_inst (
  .i_core_clk(i_core_clk),
  .i_sys_rst(i_sys_rst),
  .i_cmd_valid(i_cmd_valid),
  .i_cmd(i_cmd),
  .i_cmd_arg(i_cmd_arg),
  .i_dev_clear(i_dev_clear),
  .i_get(i_get),
  .o_resp_valid(o_resp_valid),
  .o_resp_data(o_resp_data),
  .o_opt_list(o_opt_list),
  .o_srq(o_srq),
  .o_hold(o_hold),
  .o_trig_bus(o_trig_bus),
  .o_abort(o_abort),
  .o_clear_events(o_clear_events),
  .o_cal_enable(o_cal_enable),
  .o_state(o_state)
);

/* tb/ccsu_ovl_model.sv */
// Overlapped operation engine that finishes a fixed delay after it starts
`timescale 1ns/10ps
module ccsu_ovl_model #(
  parameter int DLY = 12
) (
  // Clock and request
  input wire logic i_core_clk,
  input wire logic i_go,
  // Progress pulses
  output logic o_start,
  output logic o_done
);
  int cnt = 0;
  initial o_start = 1'b0;
  initial o_done = 1'b0;
  always @(posedge i_core_clk) begin
    o_start <= i_go;
    o_done <= (cnt == 1);
    cnt <= i_go ? DLY : (cnt > 0 ? cnt - 1 : 0);
  end
endmodule

/* tb/testbench.sv */
// Self-checking bench for the common command and status unit
`timescale 1ns/10ps
module testbench;
  import ccsu_pkg::*;
  localparam logic [13:0] OPTS = 14'h0025;
  logic clk = 1'b0, rst = 1'b1, vld = 1'b0, ser = 1'b0, dclr = 1'b0, get = 1'b0;
  logic op_set = 1'b0, qst_set = 1'b0, msg_av = 1'b0, op_rd = 1'b0, qst_rd = 1'b0;
  logic go = 1'b0, psc_nv = 1'b1;
  logic [7:0] arg = 8'h00, evt = 8'h00, rd;
  ccsu_cmd_t cmd = CCSU_CMD_NONE;
  logic ost, odn, rv, srq, hold, trg, abrt, clre, cal, psc;
  logic [13:0] opt;
  logic [2:0] seen = 3'h0;
  ccsu_state_t st;
  int failures = 0;
  int num_checks = 0;
  initial forever #4 clk = ~clk;
  // Pulses are latched so a one-cycle output cannot slip between samples
  always @(posedge clk) seen <= seen | {trg, abrt, clre};
  ccsu_ovl_model ccsu_ovl_model_inst (.i_core_clk(clk), .i_go(go), .o_start(ost), .o_done(odn));
  ccsu_top #(.OPT_INSTALLED(OPTS)) ccsu_top_inst (.i_core_clk(clk), .i_sys_rst(rst),
    .i_cmd_valid(vld), .i_cmd(cmd), .i_cmd_arg(arg), .i_cmd_serial(ser), .i_dev_clear(dclr),
    .i_get(get), .i_operation_sum(op_set), .i_questionable_sum(qst_set),
    .i_msg_avail(msg_av), .i_std_event_set(evt), .i_operation_read(op_rd),
    .i_questionable_read(qst_rd), .i_ovl_start(ost), .i_ovl_done(odn),
    .i_psc_nv(psc_nv), .o_resp_valid(rv), .o_resp_data(rd), .o_opt_list(opt), .o_srq(srq),
    .o_hold(hold), .o_trig_bus(trg), .o_abort(abrt), .o_clear_events(clre),
    .o_cal_enable(cal), .o_state(st), .o_psc(psc));
  task automatic chk(string name, logic [15:0] exp, logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic chk_st(string name, ccsu_state_t exp, ccsu_state_t got);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic wait_n(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic do_reset();
    rst <= 1'b1;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    wait_n(3);
  endtask
  task automatic send(ccsu_cmd_t c, logic [7:0] a);
    @(posedge clk);
    vld <= 1'b1;
    cmd <= c;
    arg <= a;
    @(posedge clk);
    vld <= 1'b0;
    #1;
  endtask
  task automatic query(ccsu_cmd_t c, logic [7:0] exp);
    send(c, 8'h00);
    chk("resp_valid", 16'h1, {15'h0, rv});
    chk("resp_data", {8'h0, exp}, {8'h0, rd});
  endtask
  task automatic pulse_op();
    @(posedge clk);
    op_set <= 1'b1;
    @(posedge clk);
    op_set <= 1'b0;
    wait_n(2);
  endtask
  task automatic t_status();
    query(CCSU_CMD_OPT, 8'(CCSU_OPT_COUNT));
    chk("opt_list", 16'(OPTS), {2'h0, opt});
    qst_set <= 1'b1;
    msg_av <= 1'b1;
    pulse_op();
    qst_set <= 1'b0;
    query(CCSU_CMD_STB, 8'h98);
    query(CCSU_CMD_STB, 8'h98);
    send(CCSU_CMD_SRE, 8'h80);
    wait_n(2);
    chk("srq", 16'h1, {15'h0, srq});
    query(CCSU_CMD_POLL, 8'hd8);
    wait_n(1);
    chk("srq", 16'h0, {15'h0, srq});
    query(CCSU_CMD_STB, 8'hd8);
    op_rd <= 1'b1;
    wait_n(1);
    op_rd <= 1'b0;
    query(CCSU_CMD_STB, 8'h18);
    send(CCSU_CMD_SRE, 8'h00);
    pulse_op();
    chk("srq", 16'h0, {15'h0, srq});
    send(CCSU_CMD_ESE, 8'h80);
    query(CCSU_CMD_STB, 8'hb8);
    query(CCSU_CMD_ESR, 8'h80);
    query(CCSU_CMD_ESR, 8'h00);
    query(CCSU_CMD_STB, 8'h98);
    qst_rd <= 1'b1;
    wait_n(1);
    qst_rd <= 1'b0;
    query(CCSU_CMD_STB, 8'h90);
  endtask
  task automatic t_clear();
    seen = 3'h0;
    dclr <= 1'b1;
    wait_n(1);
    dclr <= 1'b0;
    wait_n(2);
    chk("clear_dev", 16'h1, {15'h0, seen[0]});
    seen = 3'h0;
    ser <= 1'b1;
    send(CCSU_CMD_RST, 8'h00);
    ser <= 1'b0;
    wait_n(2);
    chk("clear_rst", 16'h1, {15'h0, seen[0]});
    chk_st("state", CCSU_STATE_RST, st);
    evt <= 8'h80;
    wait_n(1);
    evt <= 8'h00;
    query(CCSU_CMD_STB, 8'h30);
    chk("esb_kept", 16'h20, {8'h0, rd & 8'h20});
  endtask
  task automatic t_trig_recall();
    seen = 3'h0;
    send(CCSU_CMD_TRG, 8'h00);
    wait_n(2);
    chk("trg_cmd", 16'h1, {15'h0, seen[2]});
    seen = 3'h0;
    get <= 1'b1;
    wait_n(1);
    get <= 1'b0;
    wait_n(2);
    chk("trg_get", 16'h1, {15'h0, seen[2]});
    send(CCSU_CMD_SAV, 8'h07);
    seen = 3'h0;
    send(CCSU_CMD_RCL, 8'h07);
    wait_n(2);
    chk("abort", 16'h1, {15'h0, seen[1]});
    chk("cal", 16'h0, {15'h0, cal});
    chk_st("recall", CCSU_STATE_RST, st);
    seen = 3'h0;
    send(CCSU_CMD_RCL, 8'h08);
    wait_n(2);
    chk("abort_bad", 16'h0, {15'h0, seen[1]});
  endtask
  task automatic t_wait();
    int n;
    for (int k = 0; k < 2; k++) begin
      go <= 1'b1;
      wait_n(1);
      go <= 1'b0;
      send(CCSU_CMD_WAI, 8'h00);
      chk("hold_on", 16'h1, {15'h0, hold});
      if (k == 1) begin
        send(CCSU_CMD_STB, 8'h00);
      end else begin
        n = 0;
        while (odn !== 1'b1 && n < 40) begin
          chk("hold_mid", 16'h1, {15'h0, hold});
          wait_n(1);
          n++;
        end
      end
      wait_n(2);
      chk("hold_off", 16'h0, {15'h0, hold});
      wait_n(15);
    end
  endtask
  task automatic t_psc();
    psc_nv <= 1'b0;
    send(CCSU_CMD_PSC, 8'h00);
    chk("psc_off", 16'h0, {15'h0, psc});
    send(CCSU_CMD_SRE, 8'h80);
    do_reset();
    pulse_op();
    chk("srq_kept", 16'h1, {15'h0, srq});
    psc_nv <= 1'b1;
    send(CCSU_CMD_PSC, 8'h01);
    do_reset();
    chk("psc_on", 16'h1, {15'h0, psc});
    pulse_op();
    chk("srq_clr", 16'h0, {15'h0, srq});
  endtask
  initial begin
    do_reset();
    t_status();
    t_clear();
    t_trig_recall();
    t_wait();
    t_psc();
    stop_test();
  end
  initial begin
    #400000;
    failures++;
    stop_test();
  end
endmodule
